// ==== dv/msq_far_end.sv ====
// Purpose: far-side control logic driving tests and scan pins
// Assumes: requests change just after a rising edge
// Notes: scan clock only runs while shifting
`timescale 1ns/100ps
`default_nettype none
module msq_far_end (
   input wire logic sys_clk,
   output logic [msq_pkg::FIELD_W-1:0] test_in,
   output logic extra_condition_in,
   output logic diag_mode_in,
   output logic scan_clock,
   output logic scan_serial_in
);
   initial begin
      test_in = 6'h00;
      extra_condition_in = 1'b0;
      diag_mode_in = 1'b0;
      scan_clock = 1'b0;
      scan_serial_in = 1'b0;
   end
   task automatic set_tests(input logic [5:0] t, input logic c);
      @(posedge sys_clk);
      test_in <= t;
      extra_condition_in <= c;
   endtask : set_tests
   task automatic set_mode(input logic m);
      @(posedge sys_clk);
      diag_mode_in <= m;
   endtask : set_mode
   // msb first, each level held at least four clocks
   task automatic shift_word(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         @(posedge sys_clk);
         scan_serial_in <= w[i];
         repeat (2) @(posedge sys_clk);
         scan_clock <= 1'b1;
         repeat (4) @(posedge sys_clk);
         scan_clock <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
      scan_serial_in <= 1'b0;
   endtask : shift_word
endmodule : msq_far_end
`default_nettype wire

// ==== dv/msq_seq_chk.sv ====
// Purpose: port-level assertions for the sequencer
// Assumes: one clock, async active-low reset
// Notes: bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module msq_seq_chk #(
   parameter int DEPTH = 64
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [msq_pkg::FIELD_W-1:0] test_in,
   input wire logic extra_condition_in,
   input wire logic diag_enable,
   input wire logic diag_mode_in,
   input wire logic scan_clock,
   input wire logic scan_serial_in,
   input wire logic prog_we,
   input wire logic [msq_pkg::ADDR_W-1:0] prog_addr,
   input wire logic [msq_pkg::WORD_W-1:0] prog_data,
   input wire logic [msq_pkg::USER_W-1:0] user_out,
   input wire logic [msq_pkg::USER_W-1:0] user_out_oe,
   input wire logic zero_b,
   input wire logic equal_flag,
   input wire logic [msq_pkg::ADDR_W-1:0] program_counter,
   input wire logic scan_serial_out
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_release;
      $rose(rst_b);
   endsequence
   sequence s_idle_pc;
      !diag_enable && $stable(program_counter);
   endsequence
   property p_reset_vals;
      s_release |-> program_counter == 6'h3F && zero_b == 1'b0 && equal_flag == 1'b0
         && user_out_oe == 16'h00FF;
   endproperty
   property p_boot;
      s_release |=> program_counter == 6'h3F;
   endproperty
   property p_user_steady;
      s_idle_pc [*3] |-> $stable(user_out);
   endproperty
   property p_oe_steady;
      s_idle_pc [*3] |-> $stable(user_out_oe);
   endproperty
   property p_oe_low;
      user_out_oe[7:0] == 8'hFF;
   endproperty
   property p_oe_upper;
      user_out_oe[15:8] == 8'h00 || user_out_oe[15:8] == 8'hFF;
   endproperty
   property p_sso_quiet;
      !diag_enable && $past(!diag_enable) |-> $stable(scan_serial_out);
   endproperty
   property p_eq_hold;
      s_idle_pc [*2] |-> $stable(equal_flag);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
   a_boot: assert property (p_boot) else $error("boot address lost");
   a_user_steady: assert property (p_user_steady) else $error("user out moved");
   a_oe_steady: assert property (p_oe_steady) else $error("enable moved");
   a_oe_low: assert property (p_oe_low) else $error("low byte undriven");
   a_oe_upper: assert property (p_oe_upper) else $error("upper enable split");
   a_sso_quiet: assert property (p_sso_quiet) else $error("scan out moved");
   a_eq_hold: assert property (p_eq_hold) else $error("equal flag moved");
endmodule : msq_seq_chk
`default_nettype wire

// ==== dv/tb_msq_sequencer.sv ====
// Purpose: self-checking bench for the sequencer
// Assumes: store loaded while reset is held
// Notes: fixed seed, one all-ones corner round first, then random ones
`timescale 1ns/100ps
`default_nettype none
module tb_msq_sequencer;
   localparam int DEPTH = 64;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic diag_enable = 1'b0;
   logic prog_we = 1'b0;
   logic [5:0] prog_addr = 6'h00;
   logic [31:0] prog_data = 32'h0000_0000;
   logic [5:0] test_in;
   logic extra_condition_in, diag_mode_in, scan_clock, scan_serial_in;
   logic [15:0] user_out, user_out_oe;
   logic zero_b, equal_flag, scan_serial_out;
   logic [5:0] program_counter;
   logic [31:0] mem [64];
   int n_mismatch = 0;
   int tests_run = 0;
   always #25 sys_clk = ~sys_clk;
   msq_far_end far (.sys_clk(sys_clk), .test_in(test_in), .extra_condition_in(extra_condition_in),
      .diag_mode_in(diag_mode_in), .scan_clock(scan_clock), .scan_serial_in(scan_serial_in));
   msq_sequencer #(.DEPTH(DEPTH)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .test_in(test_in),
      .extra_condition_in(extra_condition_in), .diag_enable(diag_enable),
      .diag_mode_in(diag_mode_in), .scan_clock(scan_clock), .scan_serial_in(scan_serial_in),
      .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data), .user_out(user_out),
      .user_out_oe(user_out_oe), .zero_b(zero_b), .equal_flag(equal_flag),
      .program_counter(program_counter), .scan_serial_out(scan_serial_out));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] mkw(input logic [4:0] op, input logic pol,
      input logic [2:0] tst, input logic [5:0] dat);
      logic [16:0] r;
      r = 17'($urandom);
      return {r[16], op, pol, tst, dat, r[15:0]};
   endfunction : mkw
   function automatic logic [5:0] exp_pc(input int i, input logic [5:0] tv);
      logic [5:0] seq [11] = '{6'h3F, 6'h00, 6'h01, 6'h02, 6'h02, 6'h02, 6'h02, 6'h03, 6'h04,
         6'h0A, 6'h05};
      return (i < 11) ? seq[i] : (tv & 6'h0C);
   endfunction : exp_pc
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic restart;
      @(posedge sys_clk);
      rst_b <= 1'b0;
      diag_enable <= 1'b0;
      for (int a = 0; a < 64; a++) begin
         @(posedge sys_clk);
         prog_we <= 1'b1;
         prog_addr <= 6'(a);
         prog_data <= mem[a];
      end
      @(negedge sys_clk);
      check(32'(program_counter), 32'h0000_003F, "reset pc");
      @(posedge sys_clk);
      prog_we <= 1'b0;
      rst_b <= 1'b1;
   endtask : restart
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      #200000;
      n_mismatch++;
      $display("BAD t=%0t run hung", $time);
      tally_and_finish();
   end
   initial begin
      logic [5:0] tv;
      logic [5:0] p;
      logic [31:0] w;
      logic cc;
      void'($urandom(32'h94E6));
      repeat (16) @(posedge sys_clk);
      for (int r = 0; r < 4; r++) begin
         tv = (r == 0) ? 6'h3F : 6'($urandom);
         cc = 1'(r & 1);
         far.set_tests(tv, cc);
         for (int a = 0; a < 64; a++) mem[a] = mkw(msq_pkg::OP_NEXT, 1'b0, 3'h0, 6'h00);
         mem[63] = mkw(msq_pkg::OP_JUMP_DATA, 1'b1, 3'h7, 6'h00);
         mem[0] = mkw(msq_pkg::OP_JUMP_DATA, 1'b0, 3'h7, 6'h14);
         mem[1] = mkw(msq_pkg::OP_LOAD_DATA, ~cc, 3'h6, 6'h03);
         mem[2] = mkw(msq_pkg::OP_LOOP_DATA, 1'b0, 3'h0, 6'h02);
         w = mkw(msq_pkg::OP_NEXT, 1'b0, 3'h0, 6'h00);
         mem[3] = {w[31], 3'h7, tv & 6'h2D, 6'h2D, w[15:0]};
         mem[4] = mkw(msq_pkg::OP_CALL_DATA, 1'b0, 3'h7, 6'h0A);
         mem[10] = mkw(msq_pkg::OP_RETURN, 1'b0, 3'h7, 6'h00);
         mem[5] = mkw(msq_pkg::OP_JUMP_MASK, 1'b0, 3'h7, 6'h0C);
         restart();
         @(posedge sys_clk);
         for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk);
            p = exp_pc(i, tv);
            check(32'(program_counter), 32'(p), "pc");
            check(32'(user_out), 32'(mem[p][15:0]), "user");
            check(32'(user_out_oe), {16'h0000, {8{mem[p][31]}}, 8'hFF}, "oe");
            check(32'(zero_b), 32'(i >= 3 && i <= 5), "zero");
            check(32'(equal_flag), 32'(i >= 8), "equal");
         end
         $display("round %0d done", r);
      end
      for (int a = 0; a < 64; a++) mem[a] = mkw(msq_pkg::OP_NEXT, 1'b0, 3'h0, 6'h00);
      restart();
      @(posedge sys_clk);
      diag_enable <= 1'b1;
      w = mkw(msq_pkg::OP_NEXT, 1'b0, 3'h0, 6'h00);
      far.shift_word(w);
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      check(32'(scan_serial_out), 32'(w[31]), "scan out");
      far.set_mode(1'b1);
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      check(32'(user_out), 32'(w[15:0]), "scan load");
      check(32'(user_out_oe), {16'h0000, {8{w[31]}}, 8'hFF}, "scan oe");
      far.set_mode(1'b0);
      $display("scan test done");
      tally_and_finish();
   end
endmodule : tb_msq_sequencer
bind msq_sequencer msq_seq_chk #(.DEPTH(DEPTH)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
   .test_in(test_in), .extra_condition_in(extra_condition_in), .diag_enable(diag_enable),
   .diag_mode_in(diag_mode_in), .scan_clock(scan_clock), .scan_serial_in(scan_serial_in),
   .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data), .user_out(user_out),
   .user_out_oe(user_out_oe), .zero_b(zero_b), .equal_flag(equal_flag),
   .program_counter(program_counter), .scan_serial_out(scan_serial_out));
`default_nettype wire

// ==== include/msq_link_if.sv ====
// Purpose: words passed between sequencer core, store and scan chain
// Assumes: one clock domain
// Notes: no clocking block
`timescale 1ns/100ps
`default_nettype none
interface msq_link_if;
   logic [msq_pkg::ADDR_W-1:0] fetch_addr;
   logic [msq_pkg::WORD_W-1:0] fetch_word;
   logic [msq_pkg::WORD_W-1:0] pipe_word;
   logic [msq_pkg::WORD_W-1:0] shadow_word;

   modport core (output fetch_addr, output pipe_word, input fetch_word, input shadow_word);
   modport store (input fetch_addr, output fetch_word);
   modport scan (input pipe_word, output shadow_word);
endinterface : msq_link_if
`default_nettype wire

// ==== include/msq_pkg.sv ====
// Purpose: shared constants and types of the microprogram sequencer
// Assumes: 32-bit words, 6-bit addresses
// Notes: opcode encodings are local choices
package msq_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int WORD_W = 32;
   localparam int DEPTH = 64;
   localparam int USER_W = 16;
   localparam int HALF_W = 8;
   localparam int FIELD_W = 6;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [5:0] RESET_ADDR = 6'h3F;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [5:0] FIELD_RST = 6'h00;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int DATA_LSB = 16;
   localparam int TEST_LSB = 22;
   localparam int TEST_W = 3;
   localparam int POL_BIT = 25;
   localparam int OP_LSB = 26;
   localparam int OP_W = 5;
   localparam int CONST_LSB = 22;
   localparam int CMP_OP_LSB = 28;
   localparam int OE_BIT = 31;
   localparam logic [2:0] CMP_CODE = 3'h7;

   // ---------------------------------------------------------------
   // pin synchroniser layout
   // ---------------------------------------------------------------
   localparam int SYNC_W = 10;
   localparam int SY_COND = 6;
   localparam int SY_MODE = 7;
   localparam int SY_SCLK = 8;
   localparam int SY_SDI = 9;
   localparam int COND_EQ = 7;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      NSEL_HOLD = 2'b00,
      NSEL_INC = 2'b01,
      NSEL_RET = 2'b10,
      NSEL_BR = 2'b11
   } msq_nsel_t;

   typedef enum logic [4:0] {
      OP_NEXT = 5'b00000,
      OP_WAIT_TRUE = 5'b00001,
      OP_JUMP_DATA = 5'b00010,
      OP_JUMP_DATA_ZERO = 5'b00011,
      OP_JUMP_MASK = 5'b00100,
      OP_FORK_2WAY = 5'b00101,
      OP_CALL_DATA = 5'b00110,
      OP_CALL_DATA_NEST = 5'b00111,
      OP_CALL_MASK = 5'b01000,
      OP_CALL_MASK_NEST = 5'b01001,
      OP_PUSH_NEXT = 5'b01010,
      OP_PUSH_NEXT_NEST = 5'b01011,
      OP_PUSH_DATA = 5'b01100,
      OP_PUSH_MASK = 5'b01101,
      OP_RETURN = 5'b01110,
      OP_RETURN_POP = 5'b01111,
      OP_RETURN_ELSE_DATA = 5'b10000,
      OP_RETURN_POP_ELSE = 5'b10001,
      OP_LOOP_DATA = 5'b10010,
      OP_LOOP_DATA_RELOAD = 5'b10011,
      OP_LOAD_DATA = 5'b10100,
      OP_LOAD_DATA_OUTER = 5'b10101,
      OP_LOAD_MASK = 5'b10110,
      OP_LOAD_MASK_OUTER = 5'b10111,
      OP_DEC_NEXT = 5'b11000,
      OP_DEC_JUMP = 5'b11001,
      OP_DEC_JUMP_MASK = 5'b11010,
      OP_DEC_OUTER = 5'b11011
   } msq_op_t;

endpackage : msq_pkg

// ==== rtl/msq_sequencer.sv ====
// Purpose: microprogram sequencer top with store, pipeline and scan
// Assumes: pins are asynchronous to sys_clk, 20 MHz clock
// Notes: program store loaded over the prog_* port
//
// Contract
// - program lives in 64 words of 32 bits, fetched into pipeline
// - upper pipeline half drives sequencing, lower half drives user outputs
// - next address picks current, incremented, return register or branch
// - with nothing taken the next address is program counter plus one
// - hold and wait instructions repeat the current address
// - 6-bit return register with five sources keeps return address
// - 6-bit loop counter with four sources, loaded and decremented
// - return register and counter form two-deep stack or nested counters
// - active-low zero output while loop counter is zero
// - reset forces program address 63
// - test field picks six tests, extra condition or equal flag
// - polarity 0 acts on true, polarity 1 acts on false
// - data field gives branch address, mask or count
// - test inputs masked by data bits give multi-way target
// - general opcode in bits 26 to 30
// - fifteen upper bits decoded, bit 31 only drives outputs
// - bit 31 low floats upper user byte, lower byte stays driven
// - compare format: mask 16-21, constant 22-27, opcode 28-30
// - branch, call, push, return, loop, load, decrement, compare groups
// - one instruction per clock while next one is fetched
// - shadow register shifts in, loads pipeline, captures results
// - loop: nonzero counter decrements and branches, zero falls through
// - compare sets equal flag from masked tests against constant
// - shadow shifts on scan clock while mode is low
// - pipeline loads from shadow on clock while mode is high
`timescale 1ns/100ps
`default_nettype none
module msq_sequencer #(
   parameter int DEPTH = msq_pkg::DEPTH
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [msq_pkg::FIELD_W-1:0] test_in,
   input wire logic extra_condition_in,
   input wire logic diag_enable,
   input wire logic diag_mode_in,
   input wire logic scan_clock,
   input wire logic scan_serial_in,
   input wire logic prog_we,
   input wire logic [msq_pkg::ADDR_W-1:0] prog_addr,
   input wire logic [msq_pkg::WORD_W-1:0] prog_data,
   output logic [msq_pkg::USER_W-1:0] user_out,
   output logic [msq_pkg::USER_W-1:0] user_out_oe,
   output logic zero_b,
   output logic equal_flag,
   output logic [msq_pkg::ADDR_W-1:0] program_counter,
   output logic scan_serial_out
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [msq_pkg::SYNC_W-1:0] pin_meta_r;
   logic [msq_pkg::SYNC_W-1:0] pin_sync_r;
   logic sclk_prev_r;
   logic [msq_pkg::SYNC_W-1:0] pin_raw;

   assign pin_raw = {scan_serial_in, scan_clock, diag_mode_in, extra_condition_in, test_in};

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
         sclk_prev_r <= 1'b0;
      end else begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
         sclk_prev_r <= pin_sync_r[msq_pkg::SY_SCLK];
      end
   end

   logic [msq_pkg::FIELD_W-1:0] test_s;
   logic mode_s;
   logic sclk_rise;
   logic scan_shift;
   logic scan_capture;
   logic diag_load;

   assign test_s = pin_sync_r[msq_pkg::FIELD_W-1:0];
   assign mode_s = pin_sync_r[msq_pkg::SY_MODE];
   assign sclk_rise = pin_sync_r[msq_pkg::SY_SCLK] & ~sclk_prev_r;
   assign scan_shift = diag_enable & sclk_rise & ~mode_s;
   assign scan_capture = diag_enable & sclk_rise & mode_s & ~pin_sync_r[msq_pkg::SY_SDI];
   assign diag_load = diag_enable & mode_s;

   // ---------------------------------------------------------------
   // sub-blocks
   // ---------------------------------------------------------------
   msq_link_if link ();

   msq_store #(
      .DEPTH(DEPTH)
   ) u_store (
      .sys_clk(sys_clk),
      .prog_we(prog_we),
      .prog_addr(prog_addr),
      .prog_data(prog_data),
      .link(link.store)
   );

   msq_shadow u_shadow (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .scan_shift(scan_shift),
      .scan_capture(scan_capture),
      .scan_bit(pin_sync_r[msq_pkg::SY_SDI]),
      .scan_serial_out(scan_serial_out),
      .link(link.scan)
   );

   // ---------------------------------------------------------------
   // sequencer state
   // ---------------------------------------------------------------
   logic [msq_pkg::WORD_W-1:0] pipe_r;
   logic [msq_pkg::WORD_W-1:0] pipe_nxt;
   logic [msq_pkg::ADDR_W-1:0] pc_r;
   logic [msq_pkg::ADDR_W-1:0] pc_nxt;
   logic [msq_pkg::ADDR_W-1:0] ret_r;
   logic [msq_pkg::ADDR_W-1:0] ret_nxt;
   logic [msq_pkg::ADDR_W-1:0] cnt_r;
   logic [msq_pkg::ADDR_W-1:0] cnt_nxt;
   logic eq_r;
   logic eq_nxt;
   logic boot_r;

   // ---------------------------------------------------------------
   // field decode
   // ---------------------------------------------------------------
   logic [msq_pkg::FIELD_W-1:0] data_f;
   logic [msq_pkg::FIELD_W-1:0] const_f;
   logic [msq_pkg::TEST_W-1:0] test_f;
   logic pol_f;
   logic is_cmp;
   msq_pkg::msq_op_t op_f;
   logic [msq_pkg::FIELD_W-1:0] masked_t;
   logic [msq_pkg::ADDR_W-1:0] pc_inc;
   logic [msq_pkg::ADDR_W-1:0] cnt_dec;
   logic [msq_pkg::ADDR_W-1:0] ret_dec;
   logic [7:0] cond_vec;
   logic pass;
   logic cnt_zero;

   assign data_f = pipe_r[msq_pkg::DATA_LSB +: msq_pkg::FIELD_W];
   assign const_f = pipe_r[msq_pkg::CONST_LSB +: msq_pkg::FIELD_W];
   assign test_f = pipe_r[msq_pkg::TEST_LSB +: msq_pkg::TEST_W];
   assign pol_f = pipe_r[msq_pkg::POL_BIT];
   assign is_cmp = pipe_r[msq_pkg::CMP_OP_LSB +: 3] == msq_pkg::CMP_CODE;
   assign op_f = msq_pkg::msq_op_t'(pipe_r[msq_pkg::OP_LSB +: msq_pkg::OP_W]);
   assign masked_t = test_s & data_f;
   assign pc_inc = pc_r + 6'h01;
   assign cnt_dec = cnt_r - 6'h01;
   assign ret_dec = ret_r - 6'h01;
   assign cnt_zero = cnt_r == msq_pkg::FIELD_RST;
   assign cond_vec = {eq_r, pin_sync_r[msq_pkg::SY_COND], test_s};
   assign pass = cond_vec[test_f] ^ pol_f;

   // ---------------------------------------------------------------
   // next-address, return and counter logic
   // ---------------------------------------------------------------
   msq_pkg::msq_nsel_t nsel;
   logic [msq_pkg::ADDR_W-1:0] br_tgt;
   logic [msq_pkg::ADDR_W-1:0] next_addr;

   always_comb begin
      nsel = msq_pkg::NSEL_INC;
      br_tgt = data_f;
      ret_nxt = ret_r;
      cnt_nxt = cnt_r;
      eq_nxt = eq_r;
      if (boot_r) begin
         nsel = msq_pkg::NSEL_HOLD;
      end else if (is_cmp) begin
         eq_nxt = masked_t == const_f;
      end else begin
         case (op_f)
            msq_pkg::OP_NEXT: begin
               nsel = msq_pkg::NSEL_INC;
            end
            msq_pkg::OP_WAIT_TRUE: begin
               if (!pass) nsel = msq_pkg::NSEL_HOLD;
            end
            msq_pkg::OP_JUMP_DATA: begin
               if (pass) nsel = msq_pkg::NSEL_BR;
            end
            msq_pkg::OP_JUMP_DATA_ZERO: begin
               if (pass || cnt_zero) nsel = msq_pkg::NSEL_BR;
            end
            msq_pkg::OP_JUMP_MASK: begin
               br_tgt = masked_t;
               if (pass) nsel = msq_pkg::NSEL_BR;
            end
            msq_pkg::OP_FORK_2WAY: begin
               nsel = msq_pkg::NSEL_BR;
               br_tgt = pass ? data_f : masked_t;
            end
            msq_pkg::OP_CALL_DATA, msq_pkg::OP_CALL_DATA_NEST,
            msq_pkg::OP_CALL_MASK, msq_pkg::OP_CALL_MASK_NEST: begin
               if (op_f == msq_pkg::OP_CALL_MASK || op_f == msq_pkg::OP_CALL_MASK_NEST) begin
                  br_tgt = masked_t;
               end
               if (pass) begin
                  nsel = msq_pkg::NSEL_BR;
                  ret_nxt = pc_inc;
                  if (op_f == msq_pkg::OP_CALL_DATA_NEST
                        || op_f == msq_pkg::OP_CALL_MASK_NEST) begin
                     cnt_nxt = ret_r;
                  end
               end
            end
            msq_pkg::OP_PUSH_NEXT: begin
               if (pass) ret_nxt = pc_inc;
            end
            msq_pkg::OP_PUSH_NEXT_NEST: begin
               if (pass) begin
                  ret_nxt = pc_inc;
                  cnt_nxt = ret_r;
               end
            end
            msq_pkg::OP_PUSH_DATA: begin
               if (pass) ret_nxt = data_f;
            end
            msq_pkg::OP_PUSH_MASK: begin
               if (pass) ret_nxt = masked_t;
            end
            msq_pkg::OP_RETURN: begin
               if (pass) nsel = msq_pkg::NSEL_RET;
            end
            msq_pkg::OP_RETURN_POP: begin
               if (pass) begin
                  nsel = msq_pkg::NSEL_RET;
                  ret_nxt = cnt_r;
               end
            end
            msq_pkg::OP_RETURN_ELSE_DATA: begin
               nsel = pass ? msq_pkg::NSEL_RET : msq_pkg::NSEL_BR;
            end
            msq_pkg::OP_RETURN_POP_ELSE: begin
               nsel = pass ? msq_pkg::NSEL_RET : msq_pkg::NSEL_BR;
               if (pass) ret_nxt = cnt_r;
            end
            msq_pkg::OP_LOOP_DATA, msq_pkg::OP_LOOP_DATA_RELOAD: begin
               if (!cnt_zero) begin
                  cnt_nxt = cnt_dec;
                  nsel = msq_pkg::NSEL_BR;
               end else if (op_f == msq_pkg::OP_LOOP_DATA_RELOAD) begin
                  cnt_nxt = data_f;
               end
            end
            msq_pkg::OP_LOAD_DATA: begin
               if (pass) cnt_nxt = data_f;
            end
            msq_pkg::OP_LOAD_DATA_OUTER: begin
               if (pass) ret_nxt = data_f;
            end
            msq_pkg::OP_LOAD_MASK: begin
               if (pass) cnt_nxt = masked_t;
            end
            msq_pkg::OP_LOAD_MASK_OUTER: begin
               if (pass) ret_nxt = masked_t;
            end
            msq_pkg::OP_DEC_NEXT: begin
               if (pass) cnt_nxt = cnt_dec;
            end
            msq_pkg::OP_DEC_JUMP: begin
               if (pass) begin
                  cnt_nxt = cnt_dec;
                  nsel = msq_pkg::NSEL_BR;
               end
            end
            msq_pkg::OP_DEC_JUMP_MASK: begin
               br_tgt = masked_t;
               if (pass) begin
                  cnt_nxt = cnt_dec;
                  nsel = msq_pkg::NSEL_BR;
               end
            end
            msq_pkg::OP_DEC_OUTER: begin
               if (pass) ret_nxt = ret_dec;
            end
            default: begin
               nsel = msq_pkg::NSEL_INC;
            end
         endcase
      end
      case (nsel)
         msq_pkg::NSEL_HOLD: next_addr = pc_r;
         msq_pkg::NSEL_INC: next_addr = pc_inc;
         msq_pkg::NSEL_RET: next_addr = ret_r;
         msq_pkg::NSEL_BR: next_addr = br_tgt;
         default: next_addr = pc_inc;
      endcase
   end

   // ---------------------------------------------------------------
   // fetch and pipeline
   // ---------------------------------------------------------------
   assign link.fetch_addr = next_addr;
   assign link.pipe_word = pipe_r;

   always_comb begin
      pc_nxt = next_addr;
      pipe_nxt = diag_load ? link.shadow_word : link.fetch_word;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_r <= msq_pkg::RESET_ADDR;
         boot_r <= 1'b1;
         pipe_r <= msq_pkg::WORD_RST;
         ret_r <= msq_pkg::FIELD_RST;
         cnt_r <= msq_pkg::FIELD_RST;
         eq_r <= 1'b0;
      end else begin
         pc_r <= pc_nxt;
         boot_r <= 1'b0;
         pipe_r <= pipe_nxt;
         ret_r <= ret_nxt;
         cnt_r <= cnt_nxt;
         eq_r <= eq_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign user_out = pipe_r[msq_pkg::USER_W-1:0];
   assign user_out_oe = {{msq_pkg::HALF_W{pipe_r[msq_pkg::OE_BIT]}},
      {msq_pkg::HALF_W{1'b1}}};
   assign zero_b = ~cnt_zero;
   assign equal_flag = eq_r;
   assign program_counter = pc_r;

endmodule : msq_sequencer
`default_nettype wire

// ==== rtl/msq_shadow.sv ====
// Purpose: 32-bit shadow scan register
// Assumes: shift and capture are one-cycle pulses on sys_clk
// Notes: shifts toward the msb, msb is the serial output
`timescale 1ns/100ps
`default_nettype none
module msq_shadow (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic scan_shift,
   input wire logic scan_capture,
   input wire logic scan_bit,
   output logic scan_serial_out,
   msq_link_if.scan link
);

   // ---------------------------------------------------------------
   // shift and capture
   // ---------------------------------------------------------------
   logic [msq_pkg::WORD_W-1:0] shadow_scan_register_r;
   logic [msq_pkg::WORD_W-1:0] shadow_scan_register_nxt;

   always_comb begin
      shadow_scan_register_nxt = shadow_scan_register_r;
      if (scan_shift) begin
         shadow_scan_register_nxt = {shadow_scan_register_r[msq_pkg::WORD_W-2:0], scan_bit};
      end else if (scan_capture) begin
         shadow_scan_register_nxt = link.pipe_word;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         shadow_scan_register_r <= msq_pkg::WORD_RST;
      end else begin
         shadow_scan_register_r <= shadow_scan_register_nxt;
      end
   end

   assign link.shadow_word = shadow_scan_register_r;
   assign scan_serial_out = shadow_scan_register_r[msq_pkg::WORD_W-1];

endmodule : msq_shadow
`default_nettype wire

// ==== rtl/msq_store.sv ====
// Purpose: 64 x 32 program store
// Assumes: writes from logic on sys_clk
// Notes: read is combinational, the pipeline register follows it
`timescale 1ns/100ps
`default_nettype none
module msq_store #(
   parameter int DEPTH = msq_pkg::DEPTH
) (
   input wire logic sys_clk,
   input wire logic prog_we,
   input wire logic [msq_pkg::ADDR_W-1:0] prog_addr,
   input wire logic [msq_pkg::WORD_W-1:0] prog_data,
   msq_link_if.store link
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [msq_pkg::WORD_W-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk) begin
      if (prog_we) begin
         mem[prog_addr] <= prog_data;
      end
   end

   assign link.fetch_word = mem[link.fetch_addr];

endmodule : msq_store
`default_nettype wire
